// ==== design/fpe_pkg.sv ====
// Package with constants and types of the flash page erase control block.
package fpe_pkg;
    localparam logic [15:0] CTRL_ADR   = 16'hFE08;
    localparam logic [15:0] PROT_ADR   = 16'hFE09;
    localparam logic [15:0] STAT_ADR   = 16'hFE0A;
    localparam logic [15:0] ARRAY_END  = 16'hFE00;
    localparam logic [15:0] VEC_BASE   = 16'hFFC0;
    localparam int          VEC_BYTES  = 64;
    localparam int          TRIM_BYTES = 2;
    localparam int          VEC_OFS    = 16;
    localparam int          PAGE_BYTES = 64;
    localparam int          ROW_LSB    = 5;
    localparam logic [7:0]  ERASED     = 8'hFF;
    localparam logic [7:0]  UNMAPPED   = 8'h00;
    localparam int          PGM_BIT    = 0;
    localparam int          ERS_BIT    = 1;
    localparam int          MASS_BIT   = 2;
    localparam int          HV_BIT     = 3;
    localparam logic        CTRL_RST   = 1'b0;
    localparam logic [7:0]  PROT_RST   = 8'h00;
    localparam int          CLK_NS     = 50;
    localparam int          SETUP_NS   = 10000;
    localparam int          SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int          ERASE_NS   = 1000000;
    localparam int          ERASE_CYC  = (ERASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CNT_W      = 24;

    typedef enum logic [4:0] {
        S_IDLE  = 5'h01,
        S_SEL   = 5'h02,
        S_PROT  = 5'h04,
        S_LATCH = 5'h08,
        S_HV    = 5'h10
    } fpe_state_t;
endpackage : fpe_pkg

// ==== design/fpe_seq_if.sv ====
// Interface between the register side and the erase sequencer.
`timescale 1ns/1ns
interface fpe_seq_if;
    logic                program_select;
    logic                ers;
    logic                hv;
    logic                prot_rd;
    logic                arr_wr;
    logic                hv_allow;
    logic                erase_go;
    fpe_pkg::fpe_state_t state;

    modport ctl (output program_select, ers, hv, prot_rd, arr_wr, input hv_allow, erase_go, state);
    modport seq (input program_select, ers, hv, prot_rd, arr_wr, output hv_allow, erase_go, state);
endinterface : fpe_seq_if

// ==== design/fpe_seq.sv ====
// Step sequencer that tracks the erase and program order and times the steps.
`timescale 1ns/1ns
module fpe_seq #(
    parameter int unsigned ERASE_CYC = fpe_pkg::ERASE_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    fpe_seq_if.seq    sq
);
    fpe_pkg::fpe_state_t            state_r;
    fpe_pkg::fpe_state_t            state_nxt;
    logic [fpe_pkg::CNT_W-1:0]      cnt_r;
    logic                           sel;

    if (ERASE_CYC < 2 || ERASE_CYC >= (1 << fpe_pkg::CNT_W)) begin : g_chk
        $error("ERASE_CYC out of range for the step counter");
    end

    assign sel = sq.program_select | sq.ers;

    // Dropping the selection at the select, protect or latch step abandons the sequence.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fpe_pkg::S_IDLE:  if (sel && !sq.hv) state_nxt = fpe_pkg::S_SEL;
            fpe_pkg::S_SEL:   if (!sel) state_nxt = fpe_pkg::S_IDLE;
                              else if (sq.prot_rd) state_nxt = fpe_pkg::S_PROT;
            fpe_pkg::S_PROT:  if (!sel) state_nxt = fpe_pkg::S_IDLE;
                              else if (sq.arr_wr) state_nxt = fpe_pkg::S_LATCH;
            fpe_pkg::S_LATCH: if (!sel) state_nxt = fpe_pkg::S_IDLE;
                              else if (sq.hv) state_nxt = fpe_pkg::S_HV;
            fpe_pkg::S_HV:    if (!sq.hv) state_nxt = fpe_pkg::S_IDLE;
            default:          state_nxt = fpe_pkg::S_IDLE;
        endcase
    end

    // Step state.
    always_ff @(posedge clk_i) begin
        if (rst_i) state_r <= fpe_pkg::S_IDLE;
        else state_r <= state_nxt;
    end

    // One counter serves both the setup wait and the high voltage time; it restarts per step.
    always_ff @(posedge clk_i) begin
        if (rst_i || state_nxt != state_r) cnt_r <= '0;
        else if (cnt_r != {fpe_pkg::CNT_W{1'b1}}) cnt_r <= cnt_r + 1'b1;
    end

    assign sq.state    = state_r;
    assign sq.hv_allow = (state_r == fpe_pkg::S_LATCH)
                         && (cnt_r >= fpe_pkg::CNT_W'(fpe_pkg::SETUP_CYC));
    // Erase lands once, after the full time under high voltage with erase still selected.
    assign sq.erase_go = (state_r == fpe_pkg::S_HV) && sq.ers
                         && (cnt_r == fpe_pkg::CNT_W'(ERASE_CYC - 1));

    AST_HV_AFTER_SETUP: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == fpe_pkg::S_HV) && ($past(state_r) != fpe_pkg::S_HV)
        |-> $past(state_r) == fpe_pkg::S_LATCH
            && $past(cnt_r) >= fpe_pkg::CNT_W'(fpe_pkg::SETUP_CYC))
        else $error("High voltage step entered without setup wait");
    AST_PROT_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(state_r == fpe_pkg::S_PROT) |-> $past(state_r) == fpe_pkg::S_SEL && $past(sq.prot_rd))
        else $error("Protect step entered out of order");
    AST_ERASE_ONCE: assert property (@(posedge clk_i) disable iff (rst_i)
        sq.erase_go |=> !sq.erase_go [*8])
        else $error("Erase fired twice");
endmodule : fpe_seq

// ==== design/fpe_flash_ctrl.sv ====
// Flash array with page erase and row program control behind a Wishbone slave.
`timescale 1ns/1ns
module fpe_flash_ctrl #(
    parameter int unsigned USER_BYTES = 4096,
    parameter int unsigned ERASE_CYC  = fpe_pkg::ERASE_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [7:0]  wb_dat_i,
    input  wire logic [0:0]  wb_sel_i,
    output logic      [7:0]  wb_dat_o,
    output logic             wb_ack_o,
    output logic             high_voltage_enable_o,
    output logic             program_select_o,
    output logic             erase_select_o,
    output logic             mass_erase_select_o
);
    localparam int          UAW       = $clog2(USER_BYTES);
    localparam logic [15:0] USER_BASE = fpe_pkg::ARRAY_END - 16'(USER_BYTES);

    // Only the two documented array sizes are served.
    if (USER_BYTES != 4096 && USER_BYTES != 1536) begin : g_chk
        $error("USER_BYTES must be 4096 or 1536");
    end

    fpe_seq_if sq ();

    fpe_seq #(
        .ERASE_CYC (ERASE_CYC)
    ) u_seq (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sq    (sq)
    );

    // Array storage: the user array and the top 64 bytes holding trim and vectors.
    logic [7:0]  umem [USER_BYTES];
    logic [7:0]  vmem [fpe_pkg::VEC_BYTES];

    logic        ack_r;
    logic [7:0]  dat_r;
    logic        pgm_r;
    logic        ers_r;
    logic        mass_r;
    logic        hv_r;
    logic [7:0]  prot_r;
    logic [15:0] tgt_r;

    logic        take;
    logic        wr;
    logic        rd;
    logic        hit_user;
    logic        hit_vec;
    logic        in_array;
    logic [15:0] u_off;
    logic [UAW-1:0] u_idx;
    logic [5:0]  v_idx;
    logic        ctrl_wr;
    logic        want_pgm;
    logic        want_ers;
    logic        tgt_vec;
    logic [15:0] tgt_off;
    logic [UAW-1:0] pg_base;
    logic        same_row;
    logic        prog_wr;

    // A request is taken in the cycle before ack rises; ack then stands one cycle.
    assign take = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr   = take && wb_we_i && wb_sel_i[0];
    assign rd   = take && !wb_we_i;

    // Address decode of the user array and the vector area.
    assign hit_user = (wb_adr_i >= USER_BASE) && (wb_adr_i < fpe_pkg::ARRAY_END);
    assign v_idx    = wb_adr_i[5:0];
    assign hit_vec  = (wb_adr_i >= fpe_pkg::VEC_BASE)
                      && ((v_idx < 6'(fpe_pkg::TRIM_BYTES))
                          || (v_idx >= 6'(fpe_pkg::VEC_OFS)));
    assign in_array = hit_user || hit_vec;
    assign u_off    = wb_adr_i - USER_BASE;
    assign u_idx    = u_off[UAW-1:0];

    // The latched target decides which page an erase covers.
    assign tgt_vec  = tgt_r >= fpe_pkg::VEC_BASE;
    assign tgt_off  = tgt_r - USER_BASE;
    assign pg_base  = {tgt_off[UAW-1:6], 6'h00};

    // Programming stays inside the 32-byte row of the first write.
    assign same_row = wb_adr_i[15:fpe_pkg::ROW_LSB] == tgt_r[15:fpe_pkg::ROW_LSB];
    assign prog_wr  = wr && in_array && pgm_r && hv_r
                      && (sq.state == fpe_pkg::S_HV) && same_row;

    // Sequencer hand-off; bus reads and writes elsewhere do not disturb it.
    assign sq.program_select     = pgm_r;
    assign sq.ers     = ers_r;
    assign sq.hv      = hv_r;
    assign sq.prot_rd = rd && (wb_adr_i == fpe_pkg::PROT_ADR);
    assign sq.arr_wr  = wr && in_array && (pgm_r || ers_r) && !hv_r;

    // Control write request with the program and erase interlock applied.
    assign ctrl_wr = wr && (wb_adr_i == fpe_pkg::CTRL_ADR);
    always_comb begin
        want_pgm = wb_dat_i[fpe_pkg::PGM_BIT];
        want_ers = wb_dat_i[fpe_pkg::ERS_BIT];
        // Asking for both keeps whichever was already set; the other stays refused.
        if (want_pgm && want_ers) begin
            want_pgm = pgm_r;
            want_ers = ers_r;
        end
    end

    // Program and erase selects; reset leaves no operation selected.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pgm_r <= fpe_pkg::CTRL_RST;
            ers_r <= fpe_pkg::CTRL_RST;
        end else if (ctrl_wr) begin
            pgm_r <= want_pgm;
            ers_r <= want_ers;
        end
    end

    // Mass erase select is a plain read/write bit.
    always_ff @(posedge clk_i) begin
        if (rst_i) mass_r <= fpe_pkg::CTRL_RST;
        else if (ctrl_wr) mass_r <= wb_dat_i[fpe_pkg::MASS_BIT];
    end

    // High voltage only turns on when the sequencer has seen every step and the setup
    // time; clearing it is always accepted so software can always shut the pump off.
    // The same write must keep program or erase selected for it to turn on; a later write can still drop both while it stays on.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hv_r <= fpe_pkg::CTRL_RST;
        end else if (ctrl_wr) begin
            if (!wb_dat_i[fpe_pkg::HV_BIT]) hv_r <= 1'b0;
            else if (!hv_r && sq.hv_allow && (want_pgm || want_ers)) hv_r <= 1'b1;
        end
    end

    // Block protect value is stored for software; reading it is a sequence step.
    always_ff @(posedge clk_i) begin
        if (rst_i) prot_r <= fpe_pkg::PROT_RST;
        else if (wr && (wb_adr_i == fpe_pkg::PROT_ADR)) prot_r <= wb_dat_i;
    end

    // The first array write after the protect read picks the target page or row.
    always_ff @(posedge clk_i) begin
        if (rst_i) tgt_r <= '0;
        else if (sq.arr_wr && (sq.state == fpe_pkg::S_PROT)) tgt_r <= wb_adr_i;
    end

    // Array contents are nonvolatile: no reset. Erase writes ones, programming can
    // only clear bits, so a second program of a byte ANDs with what is stored.
    always_ff @(posedge clk_i) begin
        if (sq.erase_go) begin
            if (mass_r) begin
                for (int i = 0; i < USER_BYTES; i++) begin
                    umem[i] <= fpe_pkg::ERASED;
                end
                for (int j = 0; j < fpe_pkg::VEC_BYTES; j++) begin
                    vmem[j] <= fpe_pkg::ERASED;
                end
            end else if (tgt_vec) begin
                // Vector page erase takes the trim bytes with it.
                for (int j = 0; j < fpe_pkg::VEC_BYTES; j++) begin
                    if (j < fpe_pkg::TRIM_BYTES || j >= fpe_pkg::VEC_OFS) begin
                        vmem[j] <= fpe_pkg::ERASED;
                    end
                end
            end else begin
                for (int k = 0; k < fpe_pkg::PAGE_BYTES; k++) begin
                    umem[pg_base + UAW'(k)] <= fpe_pkg::ERASED;
                end
            end
        end else if (prog_wr) begin
            if (hit_user) umem[u_idx] <= umem[u_idx] & wb_dat_i;
            else vmem[v_idx] <= vmem[v_idx] & wb_dat_i;
        end
    end

    // Read data is registered with the ack; unmapped addresses read zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= '0;
        end else if (rd) begin
            if (wb_adr_i == fpe_pkg::CTRL_ADR) dat_r <= {4'h0, hv_r, mass_r, ers_r, pgm_r};
            else if (wb_adr_i == fpe_pkg::PROT_ADR) dat_r <= prot_r;
            else if (wb_adr_i == fpe_pkg::STAT_ADR) dat_r <= {3'h0, sq.state};
            else if (hit_user) dat_r <= umem[u_idx];
            else if (hit_vec) dat_r <= vmem[v_idx];
            else dat_r <= fpe_pkg::UNMAPPED;
        end
    end

    // Every access, mapped or not, is acknowledged one cycle after it is taken.
    always_ff @(posedge clk_i) begin
        if (rst_i) ack_r <= 1'b0;
        else ack_r <= take;
    end

    assign wb_ack_o              = ack_r;
    assign wb_dat_o              = dat_r;
    assign high_voltage_enable_o = hv_r;
    assign program_select_o      = pgm_r;
    assign erase_select_o        = ers_r;
    assign mass_erase_select_o   = mass_r;

    AST_INTERLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
        !(program_select_o && erase_select_o))
        else $error("Program and erase selected together");
    AST_RESET_CLEAR: assert property (@(posedge clk_i)
        rst_i |=> !high_voltage_enable_o && !program_select_o
                  && !erase_select_o && !mass_erase_select_o)
        else $error("Control bits not cleared by reset");
    AST_HV_RISE: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(hv_r) |-> (pgm_r || ers_r) && $past(sq.hv_allow) && $past(ctrl_wr))
        else $error("High voltage rose without a proper sequence");
    AST_PAGE_ERASE: assert property (@(posedge clk_i) disable iff (rst_i)
        sq.erase_go && !mass_r && !tgt_vec
        |=> umem[pg_base] == fpe_pkg::ERASED
            && umem[pg_base + UAW'(fpe_pkg::PAGE_BYTES - 1)] == fpe_pkg::ERASED)
        else $error("Page not erased to all ones");
    AST_VEC_TRIM: assert property (@(posedge clk_i) disable iff (rst_i)
        sq.erase_go && !mass_r && tgt_vec
        |=> vmem[0] == fpe_pkg::ERASED && vmem[1] == fpe_pkg::ERASED
            && vmem[fpe_pkg::VEC_BYTES - 1] == fpe_pkg::ERASED)
        else $error("Vector page erase missed trim or vectors");
    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Ack not a single cycle after the request");
endmodule : fpe_flash_ctrl

// ==== verification/fpe_tb.sv ====
// Self-checking testbench of the flash page erase control block.
`timescale 1ns/1ns
module testbench;
    // A short erase time keeps the run small; the erase wait below is derived from it.
    localparam int unsigned ERS = 40;
    localparam logic [15:0] CTL = fpe_pkg::CTRL_ADR;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [15:0] wb_adr_i;
    logic [7:0]  wb_dat_i;
    logic [0:0]  wb_sel_i;
    logic [7:0]  wb_dat_o;
    logic        wb_ack_o;
    logic        hv_o;
    logic        pgm_o;
    logic        ers_o;
    logic        mass_o;
    int          error_cnt;
    int          cmp_count;
    logic [31:0] seed;
    logic [15:0] a1;
    logic [15:0] a2;
    logic [7:0]  d1;
    logic [7:0]  d2;

    fpe_flash_ctrl #(.USER_BYTES(4096), .ERASE_CYC(ERS)) uut (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .wb_cyc_i              (wb_cyc_i),
        .wb_stb_i              (wb_stb_i),
        .wb_we_i               (wb_we_i),
        .wb_adr_i              (wb_adr_i),
        .wb_dat_i              (wb_dat_i),
        .wb_sel_i              (wb_sel_i),
        .wb_dat_o              (wb_dat_o),
        .wb_ack_o              (wb_ack_o),
        .high_voltage_enable_o (hv_o),
        .program_select_o      (pgm_o),
        .erase_select_o        (ers_o),
        .mass_erase_select_o   (mass_o)
    );

    // Free-running 20 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Xorshift step; a fixed start makes every run draw the same values.
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Control outputs packed in the same bit order as the control register.
    function automatic logic [7:0] pins();
        return {4'h0, hv_o, mass_o, ers_o, pgm_o};
    endfunction : pins

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // One classic Wishbone cycle; the request is held until ack is sampled high.
    task automatic wb(input logic we, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        // Ack follows the taking edge by one cycle: two edges after launch.
        chk("ack wait", n[7:0], 8'h02);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk($sformatf("read %h", a), q, e);
    endtask : rdc

    // Page or mass erase; waits are setup 200, erase ERS+4, hold 100 and recovery 20 cycles.
    task automatic erase(input logic [15:0] a, input logic [7:0] m);
        logic [7:0] q;
        wr(CTL, 8'h02 | m);
        wb(1'b0, fpe_pkg::PROT_ADR, 8'h00, q);
        // An unrelated access between steps must not disturb the sequence.
        rdc(fpe_pkg::STAT_ADR, 8'h04);
        seed = xs(seed);
        wr(a, seed[7:0]);
        repeat (200) @(posedge clk_i);
        wr(CTL, 8'h0A | m);
        chk("pins after hv", pins(), 8'h0A | m);
        repeat (ERS + 4) @(posedge clk_i);
        wr(CTL, 8'h08 | m);
        repeat (100) @(posedge clk_i);
        wr(CTL, 8'h00);
        repeat (20) @(posedge clk_i);
    endtask : erase

    // Single byte program: the first write only latches the row.
    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        wr(CTL, 8'h01);
        wb(1'b0, fpe_pkg::PROT_ADR, 8'h00, q);
        wr(a, d);
        repeat (200) @(posedge clk_i);
        wr(CTL, 8'h09);
        chk("pins in program", pins(), 8'h09);
        wr(a, d);
        wr(CTL, 8'h08);
        repeat (100) @(posedge clk_i);
        wr(CTL, 8'h00);
        repeat (20) @(posedge clk_i);
    endtask : prog

    // Main sequence: reset, interlock, refused high voltage, erase, program, mass erase.
    initial begin
        seed = 32'h4189;
        error_cnt = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 16'h0000;
        wb_dat_i = 8'h00;
        wb_sel_i = 1'b0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("pins at reset", pins(), 8'h00);
        rdc(CTL, 8'h00);
        rdc(fpe_pkg::PROT_ADR, fpe_pkg::PROT_RST);
        rdc(fpe_pkg::STAT_ADR, 8'h01);
        // The protect register keeps what software writes; reset clears it again below.
        seed = xs(seed);
        wr(fpe_pkg::PROT_ADR, seed[7:0]);
        rdc(fpe_pkg::PROT_ADR, seed[7:0]);
        wr(CTL, 8'h03);
        rdc(CTL, 8'h00);
        wr(CTL, 8'h01);
        chk("pins program", pins(), 8'h01);
        wr(CTL, 8'h03);
        chk("pins interlock", pins(), 8'h01);
        wr(CTL, 8'h09);
        chk("pins hv refused", pins(), 8'h01);
        // A reset in mid-run must drop every control bit again.
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("pins second reset", pins(), 8'h00);
        // High voltage asked for before the setup wait has elapsed is refused.
        wr(CTL, 8'h02);
        rdc(fpe_pkg::PROT_ADR, 8'h00);
        wr(16'hEE40, 8'h5A);
        wr(CTL, 8'h0A);
        chk("pins early hv", pins(), 8'h02);
        wr(CTL, 8'h00);
        erase(16'hEE40, 8'h00);
        erase(16'hEE80, 8'h00);
        erase(16'hFFE0, 8'h00);
        seed = xs(seed);
        rdc(16'hEE40 + {10'h000, seed[5:0]}, fpe_pkg::ERASED);
        rdc(16'hEE7F, fpe_pkg::ERASED);
        rdc(16'hEEBF, fpe_pkg::ERASED);
        rdc(16'hFFC0, fpe_pkg::ERASED);
        rdc(16'hFFC1, fpe_pkg::ERASED);
        rdc(16'hFFD0, fpe_pkg::ERASED);
        rdc(16'hFFFF, fpe_pkg::ERASED);
        rdc(16'hFFC5, fpe_pkg::UNMAPPED);
        rdc(16'hED00, fpe_pkg::UNMAPPED);
        seed = xs(seed);
        a1 = 16'hEE40 + {10'h000, seed[5:0]};
        a2 = 16'hEE80 + {10'h000, seed[13:8]};
        d1 = seed[23:16] & 8'h7F;
        d2 = seed[31:24] & 8'hBF;
        prog(a1, d1);
        prog(a2, d2);
        rdc(a1, d1);
        rdc(a2, d2);
        erase(16'hEE40, 8'h00);
        rdc(a1, fpe_pkg::ERASED);
        rdc(a2, d2);
        erase(16'hEE40, 8'h04);
        rdc(a2, fpe_pkg::ERASED);
        rdc(16'hEE00, fpe_pkg::ERASED);
        rdc(16'hFDFF, fpe_pkg::ERASED);
        report_and_stop();
    end

    // Watchdog: the whole sequence needs well under 5000 cycles.
    initial begin
        repeat (30000) @(posedge clk_i);
        error_cnt++;
        $display("BAD watchdog expected done seen running");
        report_and_stop();
    end
endmodule : testbench
